// ==== rtl/bitstream_pkg.sv ====
// constants and carrier types for the isolated front-end bit stream master
package bitstream_pkg;

	localparam int CHANNELS = 4;          // phases a, b, c and neutral
	localparam int PHASE_W  = 4;
	localparam int FRAME_DIV      = 16;   // master clock ticks per frame
	localparam int FRONT_END_DIV  = 4;    // master clock ticks per front-end clock
	localparam int ACC_W    = 8;
	localparam int SAMPLE_W = ACC_W + 1;
	localparam int TEMP_W   = 8;
	localparam int HIST_W   = 8;
	localparam int TCNT_W   = 4;

	// phase counter positions (one tick = one master clock enable)
	localparam logic [PHASE_W-1:0] STROBE_FIRST   = 4'h1;
	localparam logic [PHASE_W-1:0] STROBE_LAST    = 4'h4;
	localparam logic [PHASE_W-1:0] SAMPLE_PRIMARY = 4'h8;
	localparam logic [PHASE_W-1:0] SAMPLE_AUX     = 4'hc;
	localparam logic [PHASE_W-1:0] SAMPLE_TEMP    = 4'h0;
	localparam logic [PHASE_W-1:0] SAMPLE_CURRENT = 4'h4;
	localparam logic [PHASE_W-1:0] PHASE_LAST     = 4'hf;
	localparam logic [TCNT_W-1:0]  TEMP_LAST_BIT  = 4'h7;

	localparam logic [PHASE_W-1:0] PHASE_RESET  = 4'h0;
	localparam logic               FE_CLK_RESET = 1'b1;

	typedef enum logic {
		TEMP_HUNT,
		TEMP_COLLECT
	} temp_state_type;

	typedef struct packed {
		logic primary;
		logic aux;
		logic temp;
		logic current;
	} frame_bits_type;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] voltage;
		logic signed [SAMPLE_W-1:0] aux;
		logic signed [SAMPLE_W-1:0] current;
	} sample_type;

	typedef struct packed {
		frame_bits_type      bits;
		logic [ACC_W-1:0]    acc_v;
		logic [ACC_W-1:0]    acc_a;
		logic [ACC_W-1:0]    acc_i;
		logic [ACC_W-1:0]    last_v;
		logic [ACC_W-1:0]    last_a;
		logic [ACC_W-1:0]    last_i;
		sample_type          sample;
		logic [HIST_W-1:0]   hist;
		logic [TEMP_W-1:0]   tshift;
		logic [TCNT_W-1:0]   tcnt;
		temp_state_type      tstate;
		logic [TEMP_W-1:0]   temp_offset;
		logic                temp_valid;
	} chan_type;

	typedef struct packed {
		logic [PHASE_W-1:0]          phase;
		logic                        fe_clk;
		logic                        strobe;
		logic [CHANNELS-1:0]         sel;
		chan_type [CHANNELS-1:0]     ch;
		logic [ACC_W-1:0]            dec_cnt;
		logic                        frame_valid;
		logic                        sample_valid;
	} state_type;

endpackage

// ==== rtl/bitstream_master.sv ====
// master end of the front-end bit stream link: clocks, frame strobe, capture and decimation
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RULE_01] frame strobe period is sixteen master clock ticks
// [RULE_02] strobe high for one front-end clock period, low otherwise
// [RULE_03] strobe rises one tick before a front-end clock falling edge
// [RULE_04] front-end clock is master clock divided by four
// [RULE_05] four front-end clock falling edges per frame after strobe falls
// [RULE_06] front ends launch their next bit on each front-end clock fall
// [RULE_07] slot order: primary voltage, aux voltage, temperature bit, current
// [RULE_08] four separate data inputs share one frame strobe
// [RULE_09] frames repeat continuously with no idle frames
// [RULE_10] temperature bits assemble into an 8-bit signed value per channel
// [RULE_11] temperature word arrives least significant bit first
// [RULE_12] master makes the strobe and filters the modulator streams
// [RULE_13] voltage and current slots carry raw first-stage modulator bits
// [RULE_14] per-channel select: low second voltage input, high temperature sensor
// [RULE_15] absent channel tied high reads full scale, zero after high-pass
// [RULE_16] sample data at the front-end clock rise after the launching fall
// [RULE_17] parameterised delimiter detector finds bit zero of temperature word
module bitstream_master
	import bitstream_pkg::*;
#(
	parameter int               OSR           = 64,
	parameter int               DELIM_LEN     = 8,
	parameter logic [HIST_W-1:0] DELIM_PATTERN = 8'h7e
) (
	// clock, reset, enable
	input  wire logic                                     sys_clk,
	input  wire logic                                     rst_n,
	input  wire logic                                     clk_en,
	// front-end link
	output var  logic                                     front_end_clock_out,
	output var  logic                                     frame_strobe,
	output var  logic [bitstream_pkg::CHANNELS-1:0]       aux_source_select,
	input  wire logic [bitstream_pkg::CHANNELS-1:0]       data_in,
	// user side
	input  wire logic [bitstream_pkg::CHANNELS-1:0]       temp_select,
	output var  bitstream_pkg::frame_bits_type [bitstream_pkg::CHANNELS-1:0] frame_bits,
	output var  logic                                     frame_valid,
	output var  bitstream_pkg::sample_type [bitstream_pkg::CHANNELS-1:0]     samples,
	output var  logic                                     sample_valid,
	output var  logic [bitstream_pkg::CHANNELS-1:0][bitstream_pkg::TEMP_W-1:0] temp_offset,
	output var  logic [bitstream_pkg::CHANNELS-1:0]       temp_valid
);
	import bitstream_pkg::*;

	if (OSR < 2 || OSR > 255) begin : g_bad_osr
		$error("OSR must lie in 2..255");
	end
	if (DELIM_LEN < 1 || DELIM_LEN > HIST_W) begin : g_bad_delim
		$error("DELIM_LEN must lie in 1..8");
	end

	// the divider reads phase bits directly, so the package timing has to agree with it
	if (FRAME_DIV != (1 << PHASE_W) || FRONT_END_DIV != 4) begin : g_bad_div
		$error("dividers do not match the phase counter");
	end
	if (int'(STROBE_LAST) - int'(STROBE_FIRST) + 1 != FRONT_END_DIV) begin : g_bad_strobe
		$error("strobe must stand for one front-end clock period");
	end
	if (SAMPLE_PRIMARY[1:0] != 2'h0 || SAMPLE_AUX[1:0] != 2'h0 ||
			SAMPLE_TEMP[1:0] != 2'h0 || SAMPLE_CURRENT[1:0] != 2'h0) begin : g_bad_slot
		$error("slot points must sit on a front-end clock rise");
	end
	if (int'(TEMP_LAST_BIT) != TEMP_W - 1 || SAMPLE_W != ACC_W + 1) begin : g_bad_width
		$error("temperature or sample widths disagree");
	end

	localparam logic [ACC_W-1:0]  OSR_LAST   = ACC_W'(OSR - 1);
	localparam logic [HIST_W-1:0] DELIM_MASK = HIST_W'((9'h001 << DELIM_LEN) - 9'h001);
	if ((DELIM_PATTERN & ~DELIM_MASK) != '0) begin : g_bad_pattern
		$error("DELIM_PATTERN has bits above DELIM_LEN");
	end

	// first difference is the high-pass: a constant full-scale stream gives zero
	function automatic logic signed [SAMPLE_W-1:0] hp_diff(
		input logic [ACC_W-1:0] cur,
		input logic [ACC_W-1:0] prev
	);
		hp_diff = $signed({1'b0, cur}) - $signed({1'b0, prev});
	endfunction

	// one more modulator one in the window count; ACC_W is wide enough that OSR ones never wrap
	function automatic logic [ACC_W-1:0] acc_add(
		input logic [ACC_W-1:0] acc,
		input logic             bit_in
	);
		acc_add = ACC_W'(acc + ACC_W'(bit_in));
	endfunction

	function automatic logic delim_hit(input logic [HIST_W-1:0] h);
		delim_hit = (h & DELIM_MASK) == (DELIM_PATTERN & DELIM_MASK);
	endfunction

	state_type s_r;
	state_type s_nxt;

	always_comb begin
		logic               b;
		logic [PHASE_W-1:0] p;
		logic [ACC_W-1:0]   ni;
		logic [HIST_W-1:0]  h;
		logic               last_frame;
		b = 1'b0;
		p = '0;
		ni = '0;
		h = '0;
		last_frame = 1'b0;
		s_nxt = s_r;
		s_nxt.frame_valid = 1'b0;
		s_nxt.sample_valid = 1'b0;
		for (int c = 0; c < CHANNELS; c++) begin
			s_nxt.ch[c].temp_valid = 1'b0;
		end
		// a frame is sixteen ticks: strobe stands over phases 1 to 4, the front-end clock
		// falls at 2, 6, 10, 14 and rises at 0, 4, 8, 12; a bit launched on a fall is taken
		// on the next rise, so primary, aux, temperature and current land at 8, 12, 0, 4
		// free-running divider; frames follow each other with no gap
		p = (s_r.phase == PHASE_LAST) ? PHASE_RESET : PHASE_W'(s_r.phase + 4'h1); // [RULE_01] [RULE_09]
		s_nxt.phase = p;
		s_nxt.fe_clk = ~p[1]; // [RULE_04] [RULE_05]
		s_nxt.strobe = (p >= STROBE_FIRST) && (p <= STROBE_LAST); // [RULE_02] [RULE_03] [RULE_12]
		s_nxt.sel = temp_select; // [RULE_14]
		last_frame = (s_r.dec_cnt == OSR_LAST);
		if (s_r.phase == SAMPLE_CURRENT) begin
			s_nxt.frame_valid = 1'b1;
			s_nxt.dec_cnt = last_frame ? '0 : ACC_W'(s_r.dec_cnt + 8'h01);
			s_nxt.sample_valid = last_frame;
		end
		// phase_r equal to a slot point means the front-end clock has just risen
		// limitation: the first edge after release takes a stray temperature bit and the
		// first frame holds only its current bit; both age out before any word completes
		for (int c = 0; c < CHANNELS; c++) begin
			b = data_in[c]; // [RULE_08] [RULE_16]
			case (s_r.phase)
				SAMPLE_PRIMARY: begin // [RULE_07] [RULE_13]
					s_nxt.ch[c].bits.primary = b;
					s_nxt.ch[c].acc_v = acc_add(s_r.ch[c].acc_v, b);
				end
				SAMPLE_AUX: begin
					s_nxt.ch[c].bits.aux = b;
					s_nxt.ch[c].acc_a = acc_add(s_r.ch[c].acc_a, b);
				end
				SAMPLE_TEMP: begin
					s_nxt.ch[c].bits.temp = b;
					h = {s_r.ch[c].hist[HIST_W-2:0], b};
					s_nxt.ch[c].hist = h;
					case (s_r.ch[c].tstate)
						TEMP_HUNT: begin
							if (delim_hit(h)) begin // [RULE_17]
								s_nxt.ch[c].tstate = TEMP_COLLECT;
								s_nxt.ch[c].tcnt = '0;
							end
						end
						TEMP_COLLECT: begin
							s_nxt.ch[c].tshift = {b, s_r.ch[c].tshift[TEMP_W-1:1]}; // [RULE_11]
							s_nxt.ch[c].tcnt = TCNT_W'(s_r.ch[c].tcnt + 4'h1);
							// no search while collecting, so the word itself cannot restart a hunt
							if (s_r.ch[c].tcnt == TEMP_LAST_BIT) begin
								s_nxt.ch[c].temp_offset = {b, s_r.ch[c].tshift[TEMP_W-1:1]}; // [RULE_10]
								s_nxt.ch[c].temp_valid = 1'b1;
								s_nxt.ch[c].tstate = TEMP_HUNT;
							end
						end
						default: s_nxt.ch[c].tstate = TEMP_HUNT;
					endcase
				end
				SAMPLE_CURRENT: begin
					s_nxt.ch[c].bits.current = b;
					ni = acc_add(s_r.ch[c].acc_i, b);
					s_nxt.ch[c].acc_i = ni;
					if (last_frame) begin // [RULE_12]
						// tied-high input gives equal full-scale counts once two windows have passed since reset, so samples then read zero
						s_nxt.ch[c].sample.voltage = hp_diff(s_r.ch[c].acc_v, s_r.ch[c].last_v); // [RULE_15]
						s_nxt.ch[c].sample.aux = hp_diff(s_r.ch[c].acc_a, s_r.ch[c].last_a);
						s_nxt.ch[c].sample.current = hp_diff(ni, s_r.ch[c].last_i);
						s_nxt.ch[c].last_v = s_r.ch[c].acc_v;
						s_nxt.ch[c].last_a = s_r.ch[c].acc_a;
						s_nxt.ch[c].last_i = ni;
						s_nxt.ch[c].acc_v = '0;
						s_nxt.ch[c].acc_a = '0;
						s_nxt.ch[c].acc_i = '0;
					end
				end
				default: ;
			endcase
		end
	end

	// clk_en low freezes every bit of state, including the divider
	// so a one-tick pulse stands for as long as the enable stays low
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.phase <= PHASE_RESET;
			s_r.fe_clk <= FE_CLK_RESET;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// outputs are plain copies of state flops, no logic between
	always_comb begin
		front_end_clock_out = s_r.fe_clk;
		frame_strobe = s_r.strobe;
		aux_source_select = s_r.sel;
		frame_valid = s_r.frame_valid;
		sample_valid = s_r.sample_valid;
		for (int c = 0; c < CHANNELS; c++) begin
			frame_bits[c] = s_r.ch[c].bits;
			samples[c] = s_r.ch[c].sample;
			temp_offset[c] = s_r.ch[c].temp_offset;
			temp_valid[c] = s_r.ch[c].temp_valid;
		end
	end

endmodule

`default_nettype wire

// ==== verif/front_end_model.sv ====
// behavioural front end returning four bit slots per frame
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
	// link
	input  wire logic       fe_clk,
	input  wire logic       strobe,
	output var  logic       data,
	// slot contents, primary in bit3 and current in bit0
	input  wire logic [3:0] bits,
	input  wire logic [7:0] word
);
	logic [1:0]  slot_r = 2'h0;
	logic [3:0]  tidx_r = 4'h0;
	logic [15:0] tstream;
	// delimiter then word; the pattern reads the same in both bit orders
	assign tstream = {word, 8'h7e};
	initial data = 1'b0;
	always @(negedge fe_clk) begin
		if (strobe) begin
			data <= bits[0];
			slot_r <= 2'h0;
		end else begin
			case (slot_r)
				2'h0: data <= bits[3];
				2'h1: data <= bits[2];
				default: begin
					data <= tstream[tidx_r];
					tidx_r <= tidx_r + 4'h1;
				end
			endcase
			slot_r <= slot_r + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ==== verif/bitstream_props.sv ====
// link timing properties for the bit stream master
`timescale 1ns/1ps
`default_nettype none
module bitstream_props (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       clk_en,
	input wire logic       front_end_clock_out,
	input wire logic       frame_strobe,
	input wire logic [3:0] aux_source_select,
	input wire logic [3:0] temp_select,
	input wire logic       frame_valid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n || !clk_en);
	property p_div4;
		$rose(front_end_clock_out) |-> front_end_clock_out[*2] ##1 !front_end_clock_out[*2]
			##1 front_end_clock_out;
	endproperty
	a_div4: assert property (p_div4) else $error("bad front-end clock");
	property p_width; $rose(frame_strobe) |-> frame_strobe[*4] ##1 !frame_strobe; endproperty
	a_width: assert property (p_width) else $error("bad strobe width");
	property p_period; $rose(frame_strobe) |-> ##16 $rose(frame_strobe); endproperty
	a_period: assert property (p_period) else $error("bad strobe period");
	property p_lead; $rose(frame_strobe) |-> front_end_clock_out ##1 $fell(front_end_clock_out);
	endproperty
	a_lead: assert property (p_lead) else $error("bad strobe lead");
	property p_falls;
		$fell(frame_strobe) |-> ##1 $fell(front_end_clock_out) ##4 $fell(front_end_clock_out)
			##4 $fell(front_end_clock_out) ##4 $fell(front_end_clock_out);
	endproperty
	a_falls: assert property (p_falls) else $error("bad slot edges");
	property p_fvalid; frame_valid |-> $fell(frame_strobe); endproperty
	a_fvalid: assert property (p_fvalid) else $error("bad frame valid");
	property p_repeat; frame_valid |-> ##16 frame_valid; endproperty
	a_repeat: assert property (p_repeat) else $error("missing frame");
	property p_sel; aux_source_select == $past(temp_select); endproperty
	a_sel: assert property (p_sel) else $error("bad select");
	c_strobe: cover property ($rose(frame_strobe));
	c_frame: cover property (frame_valid);
	c_sel: cover property ($rose(aux_source_select[0]));
endmodule
bind bitstream_master bitstream_props u_props (.sys_clk, .rst_n, .clk_en, .front_end_clock_out,
	.frame_strobe, .aux_source_select, .temp_select, .frame_valid);
`default_nettype wire

// ==== verif/bitstream_master_tb_top.sv ====
// self-checking bench for the bit stream master
`timescale 1ns/1ps
`default_nettype none
module bitstream_master_tb_top;
	import bitstream_pkg::*;
	typedef struct packed {logic [3:0] bits; logic [7:0] word;} row_type;
	localparam row_type ROWS [4] = '{'{4'h9, 8'h9c}, '{4'h6, 8'h01}, '{4'hf, 8'h80}, '{4'h0, 8'h7f}};
	localparam int TB_OSR = 4;
	logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, fe_clk, strobe, frame_valid, sample_valid;
	logic [3:0] temp_select = 4'h0, row_bits = 4'h0, aux_sel, temp_valid;
	logic [7:0] row_word = 8'h00;
	wire logic [3:0] data_in;
	frame_bits_type [3:0] frame_bits;
	sample_type [3:0] samples;
	logic [3:0][7:0] temp_offset;
	int bad_count = 0, tests_run = 0;
	// neutral front end not fitted: its line sits high
	assign data_in[3] = 1'b1;
	for (genvar c = 0; c < 3; c++) begin : g_fe
		front_end_model u_fe (.fe_clk(fe_clk), .strobe(strobe), .data(data_in[c]),
			.bits(row_bits), .word(row_word));
	end
	bitstream_master #(.OSR(TB_OSR)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.front_end_clock_out(fe_clk), .frame_strobe(strobe), .aux_source_select(aux_sel),
		.data_in(data_in), .temp_select(temp_select), .frame_bits(frame_bits),
		.frame_valid(frame_valid), .samples(samples), .sample_valid(sample_valid),
		.temp_offset(temp_offset), .temp_valid(temp_valid));
	initial forever #2 sys_clk = ~sys_clk;
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("mismatches %0d, checks %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// a mixed word may be in flight after a row change, so callers wait twice
	task automatic wait_word;
		int n;
		n = 0;
		@(negedge sys_clk);
		while (temp_valid[0] !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 400) bad_count++;
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		print_verdict;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		foreach (ROWS[i]) begin
			@(posedge sys_clk);
			row_bits <= ROWS[i].bits;
			row_word <= ROWS[i].word;
			wait_word;
			wait_word;
			for (int c = 0; c < 3; c++) begin
				check(9'(temp_offset[c]), 9'(ROWS[i].word));
				check(9'({frame_bits[c].primary, frame_bits[c].aux,
					frame_bits[c].current}), 9'({ROWS[i].bits[3:2], ROWS[i].bits[0]}));
				check(samples[c].voltage, 9'h000);
				check(samples[c].current, 9'h000);
			end
			check(9'(frame_bits[3]), 9'h00f);
			check(samples[3].current, 9'h000);
		end
		@(posedge sys_clk);
		temp_select <= 4'ha;
		repeat (2) @(negedge sys_clk);
		check(9'(aux_sel), 9'h00a);
		@(posedge sys_clk);
		temp_select <= 4'h0;
		rst_n <= 1'b0;
		@(negedge sys_clk);
		check(9'({fe_clk, strobe, aux_sel}), 9'h020);
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge sys_clk);
		check(9'({fe_clk, strobe}), 9'h003);
		@(negedge sys_clk);
		check(9'({fe_clk, strobe}), 9'h001);
		// first window after release: the tied-high neutral counts one current one per frame
		repeat (50) @(negedge sys_clk);
		check(9'(sample_valid), 9'h000);
		@(negedge sys_clk);
		check(9'(sample_valid), 9'h001);
		check(samples[3].current, 9'(TB_OSR));
		check(samples[0].current, 9'h000);
		// enable low from the next edge on: phase must hold at 6 instead of reaching 8
		@(posedge sys_clk);
		clk_en <= 1'b0;
		repeat (3) @(negedge sys_clk);
		check(9'({fe_clk, strobe, sample_valid}), 9'h000);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		repeat (3) @(negedge sys_clk);
		check(9'({fe_clk, strobe}), 9'h002);
		print_verdict;
	end
endmodule
`default_nettype wire
